// ### inc/msc_pkg.sv
/*
 * msc_pkg: constants and carrier types of the message segmentation and
 * channel scheduler.
 * assumes one clock domain; all users write msc_pkg::name.
 */
package msc_pkg;

   // -----------------------------------------------------------------
   // sizes
   // -----------------------------------------------------------------
   localparam int NUM_TX_CH     = 16;
   localparam int NUM_RX_FLOW   = 32;
   localparam int NUM_TX_CTX    = 4;
   localparam int NUM_RX_CTX    = 8;
   localparam int CREDIT_CHUNKS = 16;
   localparam logic [8:0] SEG_MAX_BYTES = 9'h100;
   localparam logic [8:0] BUF_BYTES     = 9'h100;
   localparam logic [8:0] BURST_ROUND   = 9'h03F;
   localparam int BURST_SHIFT   = 6;
   localparam logic [4:0] CHUNK_RESET   = 5'h10;
   localparam logic [2:0] CTX_NUM_RESET = 3'h4;

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic        link;       // more descriptors follow for this message
      logic [2:0]  prio;       // lower value is served first
      logic [8:0]  seg_size;   // 0 means 256
      logic [15:0] pkt_len;    // bytes, nonzero
   } msc_desc_t;

   typedef struct packed {
      logic [3:0]  chan;
      logic [1:0]  ctx;
      logic [8:0]  len;
      logic [2:0]  bursts;     // 64-byte fetch bursts for this segment
      logic [8:0]  buf_bytes;  // buffer space taken
      logic        last;
   } msc_seg_t;

   typedef struct packed {
      logic        type11;
      logic        first;
      logic        last;
      logic [8:0]  len;
   } msc_rx_in_t;

   typedef struct packed {
      logic [4:0]  flow;
      logic [7:0]  queue;
      logic        link;       // descriptor linked to the next one
      logic [8:0]  buf_bytes;
   } msc_rx_out_t;

   typedef enum logic [2:0] {
      CTX_IDLE  = 3'b001,
      CTX_SEG   = 3'b010,
      CTX_CHAIN = 3'b100
   } msc_ctx_state_t;

endpackage : msc_pkg

// ### verilog/msc_scheduler.sv
/*
 * msc_scheduler: transmit channel arbitration, segmentation contexts,
 * credit chunk accounting and receive flow spreading.
 * assumes descriptor sources and credit buffers run on i_clk and hold
 * a descriptor valid until it is taken.
 */
`timescale 1ns/1ns
module msc_scheduler
(
   input  wire logic                 i_clk,
   input  wire logic                 i_resetn,
   input  wire logic [15:0]          i_desc_valid,
   input  msc_pkg::msc_desc_t        i_desc [msc_pkg::NUM_TX_CH],
   output logic      [15:0]          o_desc_taken,
   input  wire logic [2:0]           i_tx_ctx_num,
   input  wire logic                 i_chunk_release,
   output logic                      o_seg_valid,
   output msc_pkg::msc_seg_t         o_seg,
   output logic      [4:0]           o_chunk_free,
   output logic      [3:0]           o_ctx_busy,
   input  wire logic                 i_rx_valid,
   input  msc_pkg::msc_rx_in_t       i_rx,
   input  wire logic                 i_rx_phy_full,
   input  wire logic [31:0]          i_flow_en,
   input  wire logic [7:0]           i_flow_queue [msc_pkg::NUM_RX_FLOW],
   input  wire logic [3:0]           i_rx_ctx_num,
   output logic                      o_rx_valid,
   output msc_pkg::msc_rx_out_t      o_rx,
   output logic                      o_rx_retry
);

   // -----------------------------------------------------------------
   // context state
   // -----------------------------------------------------------------
   msc_pkg::msc_ctx_state_t ctx_state_r [msc_pkg::NUM_TX_CTX];
   logic [3:0]              ctx_chan_r  [msc_pkg::NUM_TX_CTX];
   logic [15:0]             ctx_rem_r   [msc_pkg::NUM_TX_CTX];
   logic [8:0]              ctx_seg_r   [msc_pkg::NUM_TX_CTX];
   logic                    ctx_link_r  [msc_pkg::NUM_TX_CTX];
   logic [8:0]              ctx_len     [msc_pkg::NUM_TX_CTX];
   logic [15:0]             bound;
   logic [15:0]             chain_take  [msc_pkg::NUM_TX_CTX];
   logic [3:0]              last_grant_r;
   logic [1:0]              emit_ptr_r;
   logic [4:0]              chunk_free_r;

   genvar g;
   generate
      for (g = 0; g < msc_pkg::NUM_TX_CTX; g++)
      begin : g_ctx
         logic [8:0] eff;
         // zero or oversize fields clamp to the 256-byte ceiling
         assign eff = (ctx_seg_r[g] == 9'h000 ||
                       ctx_seg_r[g] > msc_pkg::SEG_MAX_BYTES) ?
                      msc_pkg::SEG_MAX_BYTES : ctx_seg_r[g];
         assign ctx_len[g] = (ctx_rem_r[g] < {7'h00, eff}) ?
                             ctx_rem_r[g][8:0] : eff;
         assign chain_take[g] = (ctx_state_r[g] == msc_pkg::CTX_CHAIN &&
                                 i_desc_valid[ctx_chan_r[g]]) ?
                                (16'h0001 << ctx_chan_r[g]) : 16'h0000;
      end
   endgenerate

   // -----------------------------------------------------------------
   // arbitration and emission choice
   // -----------------------------------------------------------------
   logic       grant;
   logic [3:0] grant_ch;
   logic [1:0] free_ctx;
   logic       emit;
   logic [1:0] emit_ctx;
   logic [15:0] taken;

   always_comb
   begin
      logic [2:0] best;
      logic       any;
      logic       found;
      logic       ffound;
      logic       efound;
      logic [3:0] idx;
      logic [1:0] cidx;
      best     = 3'h7;
      any      = 1'b0;
      found    = 1'b0;
      ffound   = 1'b0;
      efound   = 1'b0;
      idx      = 4'h0;
      cidx     = 2'h0;
      grant_ch = 4'h0;
      free_ctx = 2'h0;
      emit_ctx = 2'h0;
      bound    = 16'h0000;
      taken    = 16'h0000;
      for (int i = 0; i < msc_pkg::NUM_TX_CTX; i++)
      begin
         if (ctx_state_r[i] != msc_pkg::CTX_IDLE)
            bound = bound | (16'h0001 << ctx_chan_r[i]);
         taken = taken | chain_take[i];
         if (!ffound && ctx_state_r[i] == msc_pkg::CTX_IDLE &&
             3'(i) < i_tx_ctx_num)
         begin
            ffound   = 1'b1;
            free_ctx = 2'(i);
         end
      end
      for (int c = 0; c < msc_pkg::NUM_TX_CH; c++)
      begin
         if (i_desc_valid[c] && !bound[c] && i_desc[c].prio <= best)
         begin
            best = i_desc[c].prio;
            any  = 1'b1;
         end
      end
      for (int k = 1; k <= msc_pkg::NUM_TX_CH; k++)
      begin
         idx = last_grant_r + 4'(k);
         if (any && !found && i_desc_valid[idx] && !bound[idx] &&
             i_desc[idx].prio == best)
         begin
            found    = 1'b1;
            grant_ch = idx;
         end
      end
      for (int k = 1; k <= msc_pkg::NUM_TX_CTX; k++)
      begin
         cidx = emit_ptr_r + 2'(k);
         if (!efound && ctx_state_r[cidx] == msc_pkg::CTX_SEG)
         begin
            efound   = 1'b1;
            emit_ctx = cidx;
         end
      end
      // a fresh grant needs a free chunk for its first segment
      grant = found && ffound && chunk_free_r != 5'h00;
      emit  = efound && chunk_free_r != 5'h00;
      if (grant)
         taken = taken | (16'h0001 << grant_ch);
   end

   // -----------------------------------------------------------------
   // transmit contexts, several run side by side
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      for (int i = 0; i < msc_pkg::NUM_TX_CTX; i++)
      begin
         if (!i_resetn)
         begin
            ctx_state_r[i] <= msc_pkg::CTX_IDLE;
            ctx_chan_r[i]  <= 4'h0;
            ctx_rem_r[i]   <= 16'h0000;
            ctx_seg_r[i]   <= 9'h000;
            ctx_link_r[i]  <= 1'b0;
         end
         else if (grant && free_ctx == 2'(i))
         begin
            ctx_state_r[i] <= msc_pkg::CTX_SEG;
            ctx_chan_r[i]  <= grant_ch;
            ctx_rem_r[i]   <= i_desc[grant_ch].pkt_len;
            ctx_seg_r[i]   <= i_desc[grant_ch].seg_size;
            ctx_link_r[i]  <= i_desc[grant_ch].link;
         end
         else if (emit && emit_ctx == 2'(i))
         begin
            ctx_rem_r[i] <= ctx_rem_r[i] - {7'h00, ctx_len[i]};
            if (ctx_rem_r[i] == {7'h00, ctx_len[i]})
               ctx_state_r[i] <= ctx_link_r[i] ?
                                 msc_pkg::CTX_CHAIN : msc_pkg::CTX_IDLE;
         end
         else if (chain_take[i] != 16'h0000)
         begin
            ctx_state_r[i] <= msc_pkg::CTX_SEG;
            ctx_rem_r[i]   <= i_desc[ctx_chan_r[i]].pkt_len;
            ctx_seg_r[i]   <= i_desc[ctx_chan_r[i]].seg_size;
            ctx_link_r[i]  <= i_desc[ctx_chan_r[i]].link;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         last_grant_r <= 4'hF;
         emit_ptr_r   <= 2'h3;
      end
      else
      begin
         if (grant)
            last_grant_r <= grant_ch;
         if (emit)
            emit_ptr_r <= emit_ctx;
      end
   end

   // release and use in one cycle cancel out
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         chunk_free_r <= msc_pkg::CHUNK_RESET;
      else if (emit && !i_chunk_release)
         chunk_free_r <= chunk_free_r - 5'h01;
      else if (!emit && i_chunk_release &&
               chunk_free_r != msc_pkg::CHUNK_RESET)
         chunk_free_r <= chunk_free_r + 5'h01;
   end

   // -----------------------------------------------------------------
   // transmit outputs
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_seg_valid  <= 1'b0;
         o_seg        <= '0;
         o_desc_taken <= 16'h0000;
         o_chunk_free <= msc_pkg::CHUNK_RESET;
         o_ctx_busy   <= 4'h0;
      end
      else
      begin
         o_seg_valid       <= emit;
         o_seg.chan        <= ctx_chan_r[emit_ctx];
         o_seg.ctx         <= emit_ctx;
         o_seg.len         <= ctx_len[emit_ctx];
         o_seg.bursts      <= 3'((ctx_len[emit_ctx] + msc_pkg::BURST_ROUND)
                                 >> msc_pkg::BURST_SHIFT);
         o_seg.buf_bytes   <= msc_pkg::BUF_BYTES;
         o_seg.last        <= !ctx_link_r[emit_ctx] &&
                              ctx_rem_r[emit_ctx] ==
                              {7'h00, ctx_len[emit_ctx]};
         o_desc_taken      <= taken;
         o_chunk_free      <= chunk_free_r;
         for (int i = 0; i < msc_pkg::NUM_TX_CTX; i++)
            o_ctx_busy[i] <= ctx_state_r[i] != msc_pkg::CTX_IDLE;
      end
   end

   // -----------------------------------------------------------------
   // receive flows and contexts
   // -----------------------------------------------------------------
   logic [4:0] flow_ptr_r;
   logic [3:0] rx_open_r;
   logic [4:0] next_flow;
   logic       flow_ok;
   logic       rx_accept;
   logic       rx_retry;

   always_comb
   begin
      logic [4:0] f;
      f         = 5'h00;
      flow_ok   = 1'b0;
      next_flow = 5'h00;
      for (int k = 1; k <= msc_pkg::NUM_RX_FLOW; k++)
      begin
         f = flow_ptr_r + 5'(k);
         if (!flow_ok && i_flow_en[f])
         begin
            flow_ok   = 1'b1;
            next_flow = f;
         end
      end
      // a new message needs a free receive context
      rx_accept = i_rx_valid && flow_ok && !i_rx_phy_full &&
                  !(i_rx.first && rx_open_r >= i_rx_ctx_num);
      rx_retry  = i_rx_valid && i_rx.type11 && !rx_accept;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         flow_ptr_r <= 5'h1F;
         rx_open_r  <= 4'h0;
      end
      else if (rx_accept)
      begin
         flow_ptr_r <= next_flow;
         if (i_rx.first && !i_rx.last)
            rx_open_r <= rx_open_r + 4'h1;
         else if (!i_rx.first && i_rx.last && rx_open_r != 4'h0)
            rx_open_r <= rx_open_r - 4'h1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_rx_valid <= 1'b0;
         o_rx       <= '0;
         o_rx_retry <= 1'b0;
      end
      else
      begin
         o_rx_valid     <= rx_accept;
         o_rx_retry     <= rx_retry;
         o_rx.flow      <= next_flow;
         o_rx.queue     <= i_flow_queue[next_flow];
         o_rx.link      <= !i_rx.last;
         o_rx.buf_bytes <= msc_pkg::BUF_BYTES;
      end
   end

endmodule : msc_scheduler

// ### tb/msc_scheduler_props.sv
/*
 * msc_scheduler_props: port-level checks of the scheduler.
 * assumes one clock domain and that flow maps stay steady while used.
 */
`timescale 1ns/1ns
module msc_scheduler_props
(
   input  wire logic                 i_clk,
   input  wire logic                 i_resetn,
   input  wire logic [2:0]           i_tx_ctx_num,
   input  wire logic                 i_rx_valid,
   input  msc_pkg::msc_rx_in_t       i_rx,
   input  wire logic                 i_rx_phy_full,
   input  wire logic [31:0]          i_flow_en,
   input  wire logic [7:0]           i_flow_queue [msc_pkg::NUM_RX_FLOW],
   input  wire logic [15:0]          o_desc_taken,
   input  wire logic                 o_seg_valid,
   input  msc_pkg::msc_seg_t         o_seg,
   input  wire logic [4:0]           o_chunk_free,
   input  wire logic [3:0]           o_ctx_busy,
   input  wire logic                 o_rx_valid,
   input  msc_pkg::msc_rx_out_t      o_rx,
   input  wire logic                 o_rx_retry
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // -----------------------------------------------------------------
   // transmit
   // -----------------------------------------------------------------
   property p_seg_max;
      o_seg_valid |-> o_seg.len <= 9'h100 && o_seg.len != 9'h000;
   endproperty
   a_seg_max: assert property (p_seg_max)
      else $error("segment longer than 256 bytes");
   property p_seg_buf;
      o_seg_valid |-> o_seg.buf_bytes == 9'h100;
   endproperty
   a_seg_buf: assert property (p_seg_buf)
      else $error("segment chunk not 256 bytes");
   property p_seg_burst;
      o_seg_valid |-> {o_seg.bursts, 6'h00} >= o_seg.len &&
                      {o_seg.bursts, 6'h00} < o_seg.len + 10'h040;
   endproperty
   a_seg_burst: assert property (p_seg_burst)
      else $error("burst count wrong");
   property p_seg_ctx;
      o_seg_valid |-> o_ctx_busy[o_seg.ctx];
   endproperty
   a_seg_ctx: assert property (p_seg_ctx)
      else $error("segment from idle context");
   property p_taken_busy;
      // busy flags lag the take pulse by one cycle
      |o_desc_taken |=> |o_ctx_busy;
   endproperty
   a_taken_busy: assert property (p_taken_busy)
      else $error("descriptor taken with no context");
   property p_ctx_limit;
      (o_ctx_busy >> i_tx_ctx_num) == 4'h0;
   endproperty
   a_ctx_limit: assert property (p_ctx_limit)
      else $error("disabled context busy");
   property p_chunk_max;
      o_chunk_free <= 5'h10;
   endproperty
   a_chunk_max: assert property (p_chunk_max)
      else $error("credit count above 16");
   // -----------------------------------------------------------------
   // receive
   // -----------------------------------------------------------------
   property p_rx_acc;
      o_rx_valid |-> $past(i_rx_valid && !i_rx_phy_full)
         && i_flow_en[o_rx.flow] && o_rx.buf_bytes == 9'h100;
   endproperty
   a_rx_acc: assert property (p_rx_acc)
      else $error("bad receive acceptance");
   property p_rx_queue;
      o_rx_valid |-> o_rx.queue == i_flow_queue[o_rx.flow];
   endproperty
   a_rx_queue: assert property (p_rx_queue)
      else $error("flow mapped to wrong queue");
   property p_rx_link;
      o_rx_valid |-> o_rx.link == !$past(i_rx.last);
   endproperty
   a_rx_link: assert property (p_rx_link)
      else $error("receive link wrong");
   property p_retry;
      o_rx_retry |-> $past(i_rx_valid && i_rx.type11) && !o_rx_valid;
   endproperty
   a_retry: assert property (p_retry)
      else $error("retry without refused type 11");
endmodule : msc_scheduler_props
bind msc_scheduler msc_scheduler_props msc_scheduler_props_inst
(
   .i_clk(i_clk), .i_resetn(i_resetn), .i_tx_ctx_num(i_tx_ctx_num),
   .i_rx_valid(i_rx_valid), .i_rx(i_rx), .i_rx_phy_full(i_rx_phy_full),
   .i_flow_en(i_flow_en), .i_flow_queue(i_flow_queue),
   .o_desc_taken(o_desc_taken), .o_seg_valid(o_seg_valid), .o_seg(o_seg),
   .o_chunk_free(o_chunk_free), .o_ctx_busy(o_ctx_busy),
   .o_rx_valid(o_rx_valid), .o_rx(o_rx), .o_rx_retry(o_rx_retry)
);

// ### tb/msc_desc_src.sv
/*
 * msc_desc_src: descriptor queues and credit buffer of the far side.
 * assumes the bench pushes descriptors; drives on the falling edge.
 */
`timescale 1ns/1ns
module msc_desc_src
(
   input  wire logic                 i_clk,
   input  wire logic [15:0]          i_taken,
   input  wire logic                 i_seg_valid,
   input  wire logic                 i_stall,
   output logic      [15:0]          o_valid,
   output msc_pkg::msc_desc_t        o_desc [16],
   output logic                      o_release
);
   msc_pkg::msc_desc_t q [16][$];
   int                 pend;
   task automatic push(input int c, input msc_pkg::msc_desc_t d);
      q[c].push_back(d);
   endtask : push
   initial
   begin
      o_valid = 16'h0000;
      o_release = 1'b0;
      pend = 0;
      foreach (o_desc[c]) o_desc[c] = '0;
   end
   always @(negedge i_clk)
   begin
      for (int c = 0; c < 16; c++)
      begin
         if (i_taken[c] === 1'b1) void'(q[c].pop_front());
         o_valid[c] = q[c].size() != 0;
         // an empty queue inverts every bit of its last descriptor on each falling edge
         o_desc[c] = o_valid[c] ? q[c][0] : ~o_desc[c];
      end
      pend += int'(i_seg_valid === 1'b1);
      o_release = !i_stall && pend > 0;
      pend -= int'(o_release);
   end
endmodule : msc_desc_src

// ### tb/testbench.sv
/*
 * testbench: directed checks of segmentation, arbitration, credits
 * and receive flows. assumes the far side model in msc_desc_src.
 */
`timescale 1ns/1ns
module testbench;
   logic                  i_clk, i_resetn, seg_valid, rls, stall;
   logic [15:0]           dvalid, taken;
   msc_pkg::msc_desc_t    desc [msc_pkg::NUM_TX_CH];
   logic [2:0]            tx_ctx;
   logic [3:0]            rx_ctx;
   msc_pkg::msc_seg_t     seg;
   logic [4:0]            chunk_free;
   logic [3:0]            ctx_busy;
   logic                  rx_valid, phy_full, orx_valid, retry;
   msc_pkg::msc_rx_in_t   rx;
   msc_pkg::msc_rx_out_t  orx;
   logic [31:0]           flow_en;
   logic [7:0]            fq [msc_pkg::NUM_RX_FLOW];
   msc_pkg::msc_seg_t     segq [$];
   msc_pkg::msc_rx_out_t  rxq [$];
   int                    mismatches, samples_checked, retries;
   msc_scheduler msc_scheduler_inst (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_desc_valid(dvalid), .i_desc(desc), .o_desc_taken(taken),
      .i_tx_ctx_num(tx_ctx), .i_chunk_release(rls), .o_seg_valid(seg_valid),
      .o_seg(seg), .o_chunk_free(chunk_free), .o_ctx_busy(ctx_busy),
      .i_rx_valid(rx_valid), .i_rx(rx), .i_rx_phy_full(phy_full),
      .i_flow_en(flow_en), .i_flow_queue(fq), .i_rx_ctx_num(rx_ctx),
      .o_rx_valid(orx_valid), .o_rx(orx), .o_rx_retry(retry));
   msc_desc_src msc_desc_src_inst (.i_clk(i_clk), .i_taken(taken),
      .i_seg_valid(seg_valid), .i_stall(stall), .o_valid(dvalid),
      .o_desc(desc), .o_release(rls));
   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      if (seg_valid === 1'b1) segq.push_back(seg);
      if (orx_valid === 1'b1) rxq.push_back(orx);
      if (retry === 1'b1) retries++;
   end
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic final_report;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   task automatic send(int c, bit lk, logic [2:0] p, logic [8:0] ss,
                       logic [15:0] len);
      msc_desc_src_inst.push(c, '{lk, p, ss, len});
   endtask : send
   task automatic wait_segs(int n);
      for (int i = 0; i < 300 && segq.size() < n; i++) @(negedge i_clk);
      check("seg_count", segq.size(), n);
   endtask : wait_segs
   task automatic exp_seg(logic [3:0] c, logic [8:0] len, bit last);
      msc_pkg::msc_seg_t s;
      if (segq.size() == 0) return;
      s = segq.pop_front();
      check("seg_chan", s.chan, c);
      check("seg_len", s.len, len);
      check("seg_bursts", s.bursts, (len + 63) / 64);
      check("seg_buf", s.buf_bytes, 32'h0000_0100);
      check("seg_last", s.last, last);
   endtask : exp_seg
   task automatic rx_pkt(bit t11, bit f, bit l, bit full);
      @(negedge i_clk);
      rx_valid = 1'b1;
      rx = '{t11, f, l, 9'h040};
      phy_full = full;
      @(negedge i_clk);
      rx_valid = 1'b0;
      phy_full = 1'b0;
      repeat (2) @(negedge i_clk);
   endtask : rx_pkt
   task automatic exp_rx(logic [4:0] f, bit lk);
      msc_pkg::msc_rx_out_t r;
      check("rx_count", rxq.size(), 1);
      if (rxq.size() == 0) return;
      r = rxq.pop_front();
      check("rx_flow", r.flow, f);
      check("rx_queue", r.queue, 8'h40 + f);
      check("rx_link", r.link, lk);
      check("rx_buf", r.buf_bytes, 32'h0000_0100);
   endtask : exp_rx
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_segment;
      send(3, 0, 0, 0, 300);
      wait_segs(2);
      exp_seg(3, 256, 0);
      exp_seg(3, 44, 1);
      send(5, 0, 0, 64, 100);
      wait_segs(2);
      exp_seg(5, 64, 0);
      exp_seg(5, 36, 1);
   endtask : t_segment
   task automatic t_chain;
      send(2, 1, 0, 0, 100);
      send(2, 0, 0, 0, 20);
      wait_segs(2);
      exp_seg(2, 100, 0);
      exp_seg(2, 20, 1);
   endtask : t_chain
   task automatic t_arbiter;
      // lower-priority channels queued with one urgent channel
      for (int c = 0; c < 3; c++) send(c, 0, 1, 0, 16);
      send(7, 0, 0, 0, 16);
      wait_segs(4);
      exp_seg(7, 16, 1);
      for (int c = 0; c < 3; c++) exp_seg(c, 16, 1);
   endtask : t_arbiter
   task automatic t_credit;
      repeat (20) @(negedge i_clk);
      check("chunks_idle", chunk_free, 5'h10);
      stall = 1'b1;
      send(4, 0, 0, 0, 4608);
      repeat (60) @(negedge i_clk);
      check("stalled_segs", segq.size(), 16);
      check("chunks_out", chunk_free, 5'h00);
      stall = 1'b0;
      wait_segs(18);
      repeat (40) @(negedge i_clk);
      check("chunks_back", chunk_free, 5'h10);
      segq.delete();
   endtask : t_credit
   task automatic t_contexts;
      tx_ctx = 3'h0;
      send(6, 0, 0, 0, 8);
      repeat (20) @(negedge i_clk);
      check("ctx_off_segs", segq.size(), 0);
      tx_ctx = 3'h4;
      wait_segs(1);
      exp_seg(6, 8, 1);
   endtask : t_contexts
   task automatic t_receive;
      for (int i = 0; i < 3; i++)
      begin
         rx_pkt(0, 1, 1, 0);
         exp_rx(5'(i % 2), 0);
      end
      rx_pkt(1, 1, 1, 1);
      check("retry_t11", retries, 1);
      rx_pkt(0, 1, 1, 1);
      check("retry_t9", retries, 1);
      check("rx_dropped", rxq.size(), 0);
      rx_pkt(0, 1, 0, 0);
      exp_rx(1, 1);
      rx_pkt(0, 0, 1, 0);
      exp_rx(0, 0);
      rx_ctx = 4'h0;
      rx_pkt(1, 1, 1, 0);
      check("retry_no_ctx", retries, 2);
      check("rx_no_ctx", rxq.size(), 0);
      rx_ctx = 4'h8;
   endtask : t_receive
   // -----------------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------------
   initial
   begin
      i_resetn = 1'b0;
      stall = 1'b0;
      tx_ctx = 3'h4;
      rx_ctx = 4'h8;
      rx_valid = 1'b0;
      rx = '0;
      phy_full = 1'b0;
      flow_en = 32'h0000_0003;
      foreach (fq[i]) fq[i] = 8'h40 + 8'(i);
      repeat (5) @(negedge i_clk);
      i_resetn = 1'b1;
      check("reset_chunks", chunk_free, 5'h10);
      t_segment();
      t_chain();
      t_arbiter();
      t_credit();
      t_contexts();
      t_receive();
      final_report();
   end
   initial
   begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      final_report();
   end
endmodule : testbench
